// >>> core/hdp_pkg.sv
package hdp_pkg;
    localparam int          ADDR_W    = 6;
    localparam int          WIN_BIT   = 5;
    localparam logic        RX_WIN    = 1'h0;
    localparam logic        TX_WIN    = 1'h1;
    localparam logic [5:0]  BLK_BYTES = 6'h20;
    localparam int          BC_W      = 12;
    localparam int          NCAUSE    = 8;
    localparam int          NCHAN     = 3;
    localparam int          NEXT      = 5;
    // Cause positions: channel register holds 0..2, extended register 3..7
    localparam int          I_MSG_END   = 0;
    localparam int          I_POOL_FULL = 1;
    localparam int          I_POOL_RDY  = 2;
    localparam int          I_MSG_REP   = 3;
    localparam int          I_TX_ERR    = 4;
    localparam int          I_EXT_EVT   = 5;
    localparam int          I_OVERFLOW  = 6;
    localparam int          I_FRM_START = 7;
    // Receive block size codes: 4, 8, 16, 32 bytes
    localparam logic [1:0]  RX_SZ_32  = 2'h3;
    localparam logic [5:0]  RX_SZ_MIN = 6'h04;
    localparam logic [7:0]  RDATA_RST = 8'h00;

    typedef enum logic [2:0] {
        HDP_IDLE = 3'b001,
        HDP_REQ  = 3'b010,
        HDP_WAIT = 3'b100
    } hdp_dma_state_e;
endpackage : hdp_pkg

// >>> core/hdp_host_port.sv
`timescale 1ns/1ps
// Operation
// - Receive and transmit buffers each occupy a 32-byte window under chip select.
// - Any address inside a window reaches the top byte of that buffer.
// - Causes show in channel or extended status; top status flags the owning register.
// - Channel status holds three causes, extended status five more.
// - A masked cause shows in no status register and raises no interrupt.
// - Masked events stay stored and appear once their mask bit clears.
// - Causes are grouped as receive, transmit and special condition sources.
// - Separate receive and transmit request outputs; one shared acknowledge input.
// - Under acknowledge, accesses reach the buffer top ignoring address and select.
// - A request stays active while transfers for its buffer remain needed.
// - Transmit request drops at the write end of transfer n-1.
// - For long messages it also drops before each 32-byte block boundary.
// - After a drop, acknowledge or select rising edge rearms if bytes remain.
// - If the final block byte passed early, request stays low until next block.
// - For 32-byte receive blocks, request drops at read end of transfer 31.
// - Receive blocks are 4, 8, 16 or 32; short ones drop at read start.
// - Reading a whole receive block by DMA acknowledges and releases it.
module hdp_host_port #(
    parameter int BC_W = hdp_pkg::BC_W
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      resetn_i,
    input  wire logic                      hdlc_chip_select_n_i,
    input  wire logic [hdp_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                      rd_n_i,
    input  wire logic                      wr_n_i,
    input  wire logic [7:0]                wdata_i,
    output logic      [7:0]                rdata_o,
    input  wire logic                      dma_acknowledge_n_i,
    output logic                           rx_dma_req_line_o,
    output logic                           tx_dma_req_line_o,
    input  wire logic [7:0]                rx_data_i,
    output logic                           rx_pop_o,
    input  wire logic                      rx_dma_enable_i,
    input  wire logic                      rx_block_valid_i,
    input  wire logic [1:0]                rx_block_size_i,
    output logic                           rx_block_ack_o,
    output logic      [7:0]                tx_data_o,
    output logic                           tx_push_o,
    input  wire logic                      tx_start_i,
    input  wire logic [BC_W-9:0]           tx_byte_count_high_i,
    input  wire logic [7:0]                tx_byte_count_low_i,
    input  wire logic [hdp_pkg::NCAUSE-1:0] irq_event_i,
    input  wire logic [hdp_pkg::NCAUSE-1:0] irq_mask_i,
    input  wire logic [hdp_pkg::NCAUSE-1:0] irq_clear_i,
    output logic      [hdp_pkg::NCHAN-1:0] channel_irq_status_o,
    output logic      [hdp_pkg::NEXT-1:0]  extended_irq_status_o,
    output logic      [1:0]                top_irq_status_o,
    output logic                           irq_o
);
    if (BC_W < 9 || BC_W > 16)
    begin : g_bad_width
        $error("hdp_host_port: BC_W must lie in 9..16");
    end

    // True when the access reaches the given window
    function automatic logic hdp_sel(input logic cs_n, input logic ack_n,
                                     input logic [hdp_pkg::ADDR_W-1:0] a, input logic win);
        hdp_sel = !ack_n || (!cs_n && a[hdp_pkg::WIN_BIT] == win);
    endfunction : hdp_sel

    logic rd_n_q;
    logic wr_n_q;
    logic ack_n_q;
    logic cs_n_q;
    logic rd_sel_q;
    logic wr_sel_q;
    logic rd_sel_now;
    logic wr_sel_now;
    logic rd_fall;
    logic rd_rise;
    logic wr_rise;
    logic trig_rise;
    logic rx_rd_done;
    logic tx_wr_done;

    assign rd_sel_now = hdp_sel(hdlc_chip_select_n_i, dma_acknowledge_n_i, addr_i,
                                hdp_pkg::RX_WIN);
    assign wr_sel_now = hdp_sel(hdlc_chip_select_n_i, dma_acknowledge_n_i, addr_i,
                                hdp_pkg::TX_WIN);
    assign rd_fall    = rd_n_q && !rd_n_i;
    assign rd_rise    = !rd_n_q && rd_n_i;
    assign wr_rise    = !wr_n_q && wr_n_i;
    assign trig_rise  = (!ack_n_q && dma_acknowledge_n_i) ||
                        (!cs_n_q && hdlc_chip_select_n_i);
    assign rx_rd_done = rd_rise && rd_sel_q;
    assign tx_wr_done = wr_rise && wr_sel_q;

    // Strobe history; the selection is held from the strobe's start
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rd_n_q   <= 1'h1;
            wr_n_q   <= 1'h1;
            ack_n_q  <= 1'h1;
            cs_n_q   <= 1'h1;
            rd_sel_q <= 1'h0;
            wr_sel_q <= 1'h0;
        end
        else
        begin
            rd_n_q  <= rd_n_i;
            wr_n_q  <= wr_n_i;
            ack_n_q <= dma_acknowledge_n_i;
            cs_n_q  <= hdlc_chip_select_n_i;
            if (rd_fall)
                rd_sel_q <= rd_sel_now;
            if (wr_n_q && !wr_n_i)
                wr_sel_q <= wr_sel_now;
        end
    end

    // Buffer data path: top byte taken at read start, write byte pushed at write end
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_o   <= hdp_pkg::RDATA_RST;
            rx_pop_o  <= 1'h0;
            tx_data_o <= hdp_pkg::RDATA_RST;
            tx_push_o <= 1'h0;
        end
        else
        begin
            rx_pop_o  <= rd_fall && rd_sel_now;
            tx_push_o <= tx_wr_done;
            if (rd_fall && rd_sel_now)
                rdata_o <= rx_data_i;
            if (!wr_n_i && wr_sel_now)
                tx_data_o <= wdata_i;
        end
    end

    // Transmit request
    hdp_pkg::hdp_dma_state_e tx_st_q;
    logic [BC_W-1:0]         tx_rem_q;
    logic [BC_W-1:0]         tx_rem_d;
    logic [5:0]              tx_left_q;
    logic [5:0]              tx_left_d;
    logic [BC_W-1:0]         tx_count;

    assign tx_count = {tx_byte_count_high_i, tx_byte_count_low_i};

    function automatic logic [5:0] hdp_tx_blk(input logic [BC_W-1:0] rem);
        hdp_tx_blk = (rem >= BC_W'(hdp_pkg::BLK_BYTES)) ? hdp_pkg::BLK_BYTES : rem[5:0];
    endfunction : hdp_tx_blk

    always_comb
    begin
        tx_rem_d  = tx_rem_q;
        tx_left_d = tx_left_q;
        if (tx_wr_done && tx_st_q != hdp_pkg::HDP_IDLE && tx_left_q != 6'h00)
        begin
            tx_rem_d  = tx_rem_q - BC_W'(1);
            tx_left_d = tx_left_q - 6'h01;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            tx_st_q   <= hdp_pkg::HDP_IDLE;
            tx_rem_q  <= '0;
            tx_left_q <= 6'h00;
        end
        else
        begin
            tx_rem_q  <= tx_rem_d;
            tx_left_q <= tx_left_d;
            case (tx_st_q)
                hdp_pkg::HDP_IDLE:
                    if (tx_start_i && tx_count != '0)
                    begin
                        tx_rem_q  <= tx_count;
                        tx_left_q <= hdp_tx_blk(tx_count);
                        tx_st_q   <= hdp_pkg::HDP_REQ;
                    end
                hdp_pkg::HDP_REQ:
                    if (tx_wr_done && tx_left_q <= 6'h02)
                        tx_st_q <= hdp_pkg::HDP_WAIT;
                hdp_pkg::HDP_WAIT:
                    if (tx_left_d == 6'h00 && tx_rem_d == '0)
                        tx_st_q <= hdp_pkg::HDP_IDLE;
                    else if (trig_rise)
                    begin
                        // A slow controller may still owe the last byte of the block
                        if (tx_left_d == 6'h00)
                            tx_left_q <= hdp_tx_blk(tx_rem_d);
                        tx_st_q <= hdp_pkg::HDP_REQ;
                    end
                default:
                    tx_st_q <= hdp_pkg::HDP_IDLE;
            endcase
        end
    end

    // Low while waiting, also after an early final byte, until the next block
    assign tx_dma_req_line_o = (tx_st_q == hdp_pkg::HDP_REQ);

    // Receive request
    hdp_pkg::hdp_dma_state_e rx_st_q;
    logic [5:0]              rx_left_q;
    logic [5:0]              rx_left_d;
    logic                    rx_big_q;

    assign rx_left_d = (rx_rd_done && rx_left_q != 6'h00) ? rx_left_q - 6'h01 : rx_left_q;

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rx_st_q        <= hdp_pkg::HDP_IDLE;
            rx_left_q      <= 6'h00;
            rx_big_q       <= 1'h0;
            rx_block_ack_o <= 1'h0;
        end
        else
        begin
            rx_left_q      <= rx_left_d;
            rx_block_ack_o <= rx_rd_done && rx_left_q == 6'h01;
            case (rx_st_q)
                hdp_pkg::HDP_IDLE:
                    if (rx_dma_enable_i && rx_block_valid_i)
                    begin
                        rx_left_q <= hdp_pkg::RX_SZ_MIN << rx_block_size_i;
                        rx_big_q  <= rx_block_size_i == hdp_pkg::RX_SZ_32;
                        rx_st_q   <= hdp_pkg::HDP_REQ;
                    end
                hdp_pkg::HDP_REQ:
                    if (rx_big_q && rx_rd_done && rx_left_q == 6'h02)
                        rx_st_q <= hdp_pkg::HDP_WAIT;
                    else if (rd_fall && rd_sel_now && rx_left_q == 6'h01)
                        rx_st_q <= hdp_pkg::HDP_WAIT;
                hdp_pkg::HDP_WAIT:
                    if (trig_rise && rx_left_d == 6'h00)
                        rx_st_q <= hdp_pkg::HDP_IDLE;
                    else if (trig_rise && rx_big_q && rd_n_i)
                        rx_st_q <= hdp_pkg::HDP_REQ;
                default:
                    rx_st_q <= hdp_pkg::HDP_IDLE;
            endcase
        end
    end

    assign rx_dma_req_line_o = (rx_st_q == hdp_pkg::HDP_REQ);

    // Interrupt causes: masked ones stay pending but invisible
    logic [hdp_pkg::NCAUSE-1:0] pend_q;
    logic [hdp_pkg::NCAUSE-1:0] vis;

    assign vis = pend_q & ~irq_mask_i;

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pend_q <= '0;
        else
            pend_q <= (pend_q & ~(irq_clear_i & vis)) | irq_event_i;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            channel_irq_status_o  <= '0;
            extended_irq_status_o <= '0;
            top_irq_status_o      <= 2'h0;
            irq_o                 <= 1'h0;
        end
        else
        begin
            channel_irq_status_o  <= vis[hdp_pkg::NCHAN-1:0];
            extended_irq_status_o <= vis[hdp_pkg::NCAUSE-1:hdp_pkg::NCHAN];
            top_irq_status_o      <= {|vis[hdp_pkg::NCAUSE-1:hdp_pkg::NCHAN],
                                      |vis[hdp_pkg::NCHAN-1:0]};
            irq_o                 <= |vis;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    chk_mask_hides: assert property (1 |=> (({extended_irq_status_o, channel_irq_status_o}
        & $past(irq_mask_i)) == '0)) else $error("masked cause visible");
    chk_unmask_shows: assert property ((irq_event_i != '0) ##1 (irq_mask_i == '0)
        |=> irq_o) else $error("stored event not reported after unmask");
    chk_top_flags: assert property (top_irq_status_o ==
        {|extended_irq_status_o, |channel_irq_status_o}) else $error("top status mismatch");
    chk_tx_drop: assert property ((tx_st_q == hdp_pkg::HDP_REQ && tx_wr_done
        && tx_left_q <= 6'h02) |=> !tx_dma_req_line_o) else $error("tx request not dropped");
    chk_tx_block_edge: assert property ((tx_st_q == hdp_pkg::HDP_REQ && tx_wr_done
        && tx_left_q == 6'h02 && tx_rem_q > 6'h02) |=> !tx_dma_req_line_o ##1 $stable(tx_rem_q))
        else $error("tx request held over block boundary");
    chk_tx_rearm: assert property ((tx_st_q == hdp_pkg::HDP_WAIT && trig_rise
        && tx_left_d == 6'h00 && tx_rem_d != '0) |=> tx_dma_req_line_o)
        else $error("tx request not rearmed");
    chk_tx_stay_low: assert property ((tx_st_q == hdp_pkg::HDP_WAIT && !trig_rise)
        |=> !tx_dma_req_line_o) else $error("tx request rose without trigger");
    chk_rx_k32_drop: assert property ((rx_st_q == hdp_pkg::HDP_REQ && rx_big_q
        && rx_rd_done && rx_left_q == 6'h02) |=> !rx_dma_req_line_o)
        else $error("rx request not dropped before block end");
    chk_rx_fall_drop: assert property ((rx_st_q == hdp_pkg::HDP_REQ && !rx_big_q
        && rd_fall && rd_sel_now && rx_left_q == 6'h01) |=> !rx_dma_req_line_o)
        else $error("short rx block request not dropped");
    chk_rx_block_ack: assert property ((rx_rd_done && rx_left_q == 6'h01)
        |=> rx_block_ack_o ##1 !rx_block_ack_o) else $error("rx block not acknowledged");
    chk_dma_top: assert property ((!dma_acknowledge_n_i && rd_fall) |=> rx_pop_o
        && rdata_o == $past(rx_data_i)) else $error("acknowledged read missed buffer top");
    chk_window_any: assert property ((dma_acknowledge_n_i && !hdlc_chip_select_n_i
        && !addr_i[hdp_pkg::WIN_BIT] && rd_fall) |=> rx_pop_o) else $error("window read lost");

    cov_tx_two_blocks: cover property ($fell(tx_dma_req_line_o) ##[1:40]
        $rose(tx_dma_req_line_o));
    cov_rx_big_block: cover property (rx_big_q && rx_block_ack_o);
    cov_masked_release: cover property ((irq_event_i & irq_mask_i) != '0 ##[1:20] irq_o);
    cov_pulsed_ack: cover property (trig_rise && tx_st_q == hdp_pkg::HDP_WAIT);
endmodule : hdp_host_port

// >>> tb/hdp_bus_model.sv
`timescale 1ns/1ps
// Host processor and demand-mode DMA controller on the parallel bus
module hdp_bus_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rx_req_i,
    output logic            cs_n_o,
    output logic [5:0]      addr_o,
    output logic            rd_n_o,
    output logic            wr_n_o,
    output logic [7:0]      wdata_o,
    output logic            ack_n_o
);
    initial
    begin
        cs_n_o  = 1'b1;
        addr_o  = 6'h00;
        rd_n_o  = 1'b1;
        wr_n_o  = 1'b1;
        wdata_o = 8'hFF;
        ack_n_o = 1'b1;
    end

    // Acknowledge is held as a level until the next call, which may come in mid-block
    task set_ack_n(input logic v);
        @(negedge clk_i);
        ack_n_o = v;
    endtask : set_ack_n

    // Select only for addressed cycles; data is scrambled once released
    task bus_write(input logic sel, input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_i);
        cs_n_o  = ~sel;
        addr_o  = a;
        wdata_o = d;
        wr_n_o  = 1'b0;
        @(negedge clk_i);
        wr_n_o = 1'b1;
        repeat (2) @(negedge clk_i);
        cs_n_o  = 1'b1;
        wdata_o = ~d;
    endtask : bus_write

    // Also samples the receive request in mid-strobe
    task bus_read(input logic sel, input logic [5:0] a, output logic [7:0] d, output logic m);
        @(negedge clk_i);
        cs_n_o = ~sel;
        addr_o = a;
        rd_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        d      = rdata_i;
        m      = rx_req_i;
        rd_n_o = 1'b1;
        repeat (2) @(negedge clk_i);
        cs_n_o = 1'b1;
    endtask : bus_read
endmodule : hdp_bus_model

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       cs_n, rd_n, wr_n, ack_n, rx_req, tx_req, rx_pop, rx_back, tx_push, irq;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, tx_data, last_push;
    logic [7:0] rx_data;
    logic [7:0] exp_rx;
    logic       rx_en;
    logic       rx_valid;
    logic [1:0] rx_size;
    logic       tx_start;
    logic [3:0] bc_hi;
    logic [7:0] bc_lo;
    logic [7:0] ev;
    logic [7:0] msk;
    logic [7:0] clr;
    logic [2:0] ch_st;
    logic [4:0] ex_st;
    logic [1:0] top_st;
    int         miscompares = 0;
    int         samples_checked = 0;
    int         pushes = 0;
    int         pops = 0;
    int         backs = 0;

    always #2 clk = ~clk;

    hdp_bus_model u_hdp_bus_model (.clk_i(clk), .rdata_i(rdata), .rx_req_i(rx_req),
        .cs_n_o(cs_n), .addr_o(addr), .rd_n_o(rd_n), .wr_n_o(wr_n), .wdata_o(wdata),
        .ack_n_o(ack_n));

    hdp_host_port u_hdp_host_port (.ref_clk_i(clk), .resetn_i(rst_n),
        .hdlc_chip_select_n_i(cs_n), .addr_i(addr), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .wdata_i(wdata), .rdata_o(rdata), .dma_acknowledge_n_i(ack_n),
        .rx_dma_req_line_o(rx_req), .tx_dma_req_line_o(tx_req), .rx_data_i(rx_data),
        .rx_pop_o(rx_pop), .rx_dma_enable_i(rx_en), .rx_block_valid_i(rx_valid),
        .rx_block_size_i(rx_size), .rx_block_ack_o(rx_back), .tx_data_o(tx_data),
        .tx_push_o(tx_push), .tx_start_i(tx_start), .tx_byte_count_high_i(bc_hi),
        .tx_byte_count_low_i(bc_lo), .irq_event_i(ev), .irq_mask_i(msk),
        .irq_clear_i(clr), .channel_irq_status_o(ch_st), .extended_irq_status_o(ex_st),
        .top_irq_status_o(top_st), .irq_o(irq));

    // Buffer ends: count one-cycle pulses, engine drops valid on block release
    always @(negedge clk)
    begin
        if (tx_push === 1'b1)
        begin
            pushes++;
            last_push = tx_data;
        end
        if (rx_pop === 1'b1)
        begin
            pops++;
            rx_data = rx_data + 8'h01;
        end
        if (rx_back === 1'b1)
        begin
            backs++;
            rx_valid = 1'b0;
        end
    end

    task compare_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare_byte

    task compare_bit(input logic got, input logic exp);
        compare_byte({7'h00, got}, {7'h00, exp});
    endtask : compare_bit

    task report_and_stop;
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    task idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    task wait_req(input logic tx);
        int n;
        for (n = 0; n < 20; n++)
        begin
            @(negedge clk);
            if ((tx ? tx_req : rx_req) === 1'b1)
                return;
        end
        miscompares++;
        report_and_stop();
    endtask : wait_req

    task start_tx(input logic [11:0] n);
        bc_hi = n[11:8];
        bc_lo = n[7:0];
        @(negedge clk);
        tx_start = 1'b1;
        @(negedge clk);
        tx_start = 1'b0;
    endtask : start_tx

    task pulse_irq(input logic [7:0] e, input logic [7:0] c);
        @(negedge clk);
        ev  = e;
        clr = c;
        @(negedge clk);
        ev  = 8'h00;
        clr = 8'h00;
    endtask : pulse_irq

    task check_irq(input logic on, input int k);
        logic [7:0] e;
        e = on ? 8'(8'h01 << k) : 8'h00;
        compare_byte({5'h00, ch_st}, {5'h00, e[2:0]});
        compare_byte({3'h0, ex_st}, {3'h0, e[7:3]});
        compare_byte({6'h00, top_st}, {6'h00, |e[7:3], |e[2:0]});
        compare_bit(irq, on);
    endtask : check_irq

    initial
    begin
        logic [7:0] d;
        logic       m;
        int         k;
        int         s;
        rx_data  = 8'h00;
        exp_rx   = 8'h00;
        rx_en    = 1'b0;
        rx_valid = 1'b0;
        rx_size  = 2'h0;
        tx_start = 1'b0;
        bc_hi    = 4'h0;
        bc_lo    = 8'h00;
        ev       = 8'h00;
        msk      = 8'h00;
        clr      = 8'h00;
        idle(4);
        rst_n = 1'b1;
        compare_bit(tx_req, 1'b0);
        compare_bit(rx_req, 1'b0);
        compare_bit(irq, 1'b0);
        compare_byte(rdata, 8'h00);
        u_hdp_bus_model.bus_write(1'b1, 6'h3A, 8'hA5);
        u_hdp_bus_model.bus_write(1'b1, 6'h05, 8'h3C);
        u_hdp_bus_model.bus_write(1'b0, 6'h20, 8'h3C);
        idle(2);
        compare_byte(pushes[7:0], 8'h01);
        compare_byte(last_push, 8'hA5);
        u_hdp_bus_model.bus_read(1'b1, 6'h15, d, m);
        compare_byte(d, exp_rx);
        exp_rx++;
        u_hdp_bus_model.bus_read(1'b1, 6'h2F, d, m);
        idle(2);
        compare_byte(pops[7:0], 8'h01);
        start_tx(12'h000);
        idle(3);
        compare_bit(tx_req, 1'b0);
        start_tx(12'h002);
        wait_req(1'b1);
        u_hdp_bus_model.set_ack_n(1'b0);
        u_hdp_bus_model.bus_write(1'b0, 6'h00, 8'h10);
        compare_bit(tx_req, 1'b0);
        u_hdp_bus_model.set_ack_n(1'b1);
        idle(2);
        compare_bit(tx_req, 1'b1);
        u_hdp_bus_model.set_ack_n(1'b0);
        u_hdp_bus_model.bus_write(1'b0, 6'h00, 8'h11);
        u_hdp_bus_model.set_ack_n(1'b1);
        idle(3);
        compare_bit(tx_req, 1'b0);
        compare_byte(last_push, 8'h11);
        start_tx(12'h021);
        wait_req(1'b1);
        u_hdp_bus_model.set_ack_n(1'b0);
        for (k = 0; k < 32; k++)
        begin
            compare_bit(tx_req, k < 31);
            u_hdp_bus_model.bus_write(1'b0, 6'h00, k[7:0]);
        end
        compare_bit(tx_req, 1'b0);
        u_hdp_bus_model.set_ack_n(1'b1);
        idle(3);
        compare_bit(tx_req, 1'b1);
        u_hdp_bus_model.set_ack_n(1'b0);
        u_hdp_bus_model.bus_write(1'b0, 6'h00, 8'h20);
        u_hdp_bus_model.set_ack_n(1'b1);
        idle(3);
        compare_bit(tx_req, 1'b0);
        compare_byte(pushes[7:0], 8'h24);
        compare_byte(last_push, 8'h20);
        rx_en = 1'b1;
        for (s = 0; s < 4; s++)
        begin
            rx_size  = s[1:0];
            rx_valid = 1'b1;
            wait_req(1'b0);
            u_hdp_bus_model.set_ack_n(1'b0);
            for (k = 0; k < (4 << s); k++)
            begin
                compare_bit(rx_req, !(s == 3 && k == 31));
                if (s == 3 && k == 31)
                begin
                    u_hdp_bus_model.set_ack_n(1'b1);
                    idle(2);
                    compare_bit(rx_req, 1'b1);
                    u_hdp_bus_model.set_ack_n(1'b0);
                end
                u_hdp_bus_model.bus_read(1'b0, 6'h2A, d, m);
                compare_byte(d, exp_rx);
                compare_bit(m, k < (4 << s) - 1);
                exp_rx++;
            end
            u_hdp_bus_model.set_ack_n(1'b1);
            idle(3);
            compare_bit(rx_req, 1'b0);
            compare_bit(tx_req, 1'b0);
            compare_byte(backs[7:0], s[7:0] + 8'h01);
        end
        for (k = 0; k < 8; k++)
        begin
            msk = 8'(8'h01 << k);
            pulse_irq(msk, 8'h00);
            idle(3);
            check_irq(1'b0, k);
            msk = 8'h00;
            idle(3);
            check_irq(1'b1, k);
            pulse_irq(8'h00, 8'(8'h01 << k));
            idle(3);
            check_irq(1'b0, k);
        end
        pulse_irq(8'h80, 8'h80);
        idle(3);
        check_irq(1'b1, 7);
        start_tx(12'h100);
        wait_req(1'b1);
        compare_bit(tx_req, 1'b1);
        msk = 8'h01;
        pulse_irq(8'h01, 8'h00);
        idle(2);
        rst_n = 1'b0;
        idle(2);
        rst_n = 1'b1;
        msk = 8'h00;
        idle(3);
        compare_bit(irq, 1'b0);
        compare_bit(tx_req, 1'b0);
        report_and_stop();
    end
endmodule : tb
